// File: design/bse_pkg.sv
// Purpose: Shared constants and types for the beam status evaluator.
// Assumes: One beam status bit per beam, bit 0 is beam 1.
// Notes: Beam count and converter width are plain defaults.
package bse_pkg;
  localparam int BSE_NUM_BEAMS = 16;
  localparam int BSE_IDX_W = 5;
  localparam int BSE_DAC_W = 12;
  localparam int BSE_PROD_W = BSE_IDX_W + BSE_DAC_W;
  localparam logic [BSE_IDX_W-1:0] BSE_IDX_NONE = 5'h00;
  localparam logic [BSE_IDX_W-1:0] BSE_IDX_ONE = 5'h01;
  localparam logic [BSE_IDX_W-1:0] BSE_BEAMS = 5'h10;
  // Code for full scale, which is ten volts at the analogue pin.
  localparam logic [BSE_DAC_W-1:0] BSE_DAC_FULL = 12'hfff;
  localparam logic [BSE_DAC_W-1:0] BSE_DAC_ZERO = 12'h000;
  localparam logic [1:0] BSE_SETTLE_CYCLES = 2'h3;
  // Analogue-only selector switch codes.
  localparam logic [1:0] BSE_AN_SPAN = 2'h0;
  localparam logic [1:0] BSE_AN_LAST_BLK = 2'h1;
  localparam logic [1:0] BSE_AN_COUNT = 2'h2;
  localparam logic [1:0] BSE_AN_FIRST_BLK = 2'h3;
  // Serial output function switch codes.
  localparam logic [2:0] BSE_SER_BITMAP = 3'h0;
  localparam logic [2:0] BSE_SER_FB_CNT = 3'h1;
  localparam logic [2:0] BSE_SER_FO_SPAN = 3'h2;
  localparam logic [2:0] BSE_SER_LB_CNT = 3'h3;
  localparam logic [2:0] BSE_SER_LO_SPAN = 3'h4;
  localparam logic [2:0] BSE_SER_CONT_MAP = 3'h5;
  localparam logic [2:0] BSE_SER_FB_LB = 3'h6;
  localparam logic [2:0] BSE_SER_HOLES = 3'h7;
  typedef enum logic [1:0] {
    BSE_CFG_SETTLE,
    BSE_CFG_LATCH,
    BSE_CFG_RUN
  } bse_cfg_state_type;
endpackage

// File: design/bse_analog_scaler.sv
// Purpose: Scales one measurement value to an analogue output code.
// Assumes: Value never exceeds the beam count.
// Notes: Division by the fixed beam count synthesises to constant logic.
`timescale 1ns/10ps
module bse_analog_scaler
  import bse_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic i_enable,
  input wire logic i_invert,
  input wire logic [BSE_IDX_W-1:0] i_value,
  output logic [BSE_DAC_W-1:0] o_code,
  output logic o_valid
);
  logic [BSE_PROD_W-1:0] product;
  logic [BSE_DAC_W-1:0] scaled;

  assign product = BSE_PROD_W'(i_value) * BSE_PROD_W'(BSE_DAC_FULL);
  assign scaled = BSE_DAC_W'(product / BSE_PROD_W'(BSE_BEAMS)); // R13

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_code <= BSE_DAC_ZERO;
    end else if (i_load) begin
      if (!i_enable) begin
        o_code <= BSE_DAC_ZERO;
      end else if (i_invert) begin
        o_code <= BSE_DAC_FULL - scaled; // R13
      end else begin
        o_code <= scaled; // R13
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
    end else begin
      o_valid <= i_load;
    end
  end
endmodule

// File: design/bse_beam_status_evaluator.sv
// Purpose: Derives position and size values from the beam status vector.
// Assumes: i_scan_tick is a one-cycle pulse from the scan sequencer.
// Notes: Bit 0 of every bitmap is beam 1, farthest from the connector.
//
// Overview of operation
// R1: Beam 1 farthest from connector, counting upward.
// R2: Open beam reads 0, blocked beam 1.
// R3: Sample all beams each scan, recompute everything.
// R4: First blocked is lowest blocked index.
// R5: First open is lowest open index.
// R6: Blocked count counts blocked beams only.
// R7: Span runs first to last blocked, holes included.
// R8: Last blocked is highest blocked index.
// R9: Last open is highest open index.
// R10: Serial variants can send the full bitmap.
// R11: Serial sends bitmap or one value pair.
// R12: Transmitter switch selects near, else far.
// R13: Analogue scales linearly, full scale ten volts.
// R14: Analogue-only variant refreshes every scan.
// R15: Switches latched at power-up, later changes ignored.
// R16: No blocked beam gives zero blocked values.
`timescale 1ns/10ps
module bse_beam_status_evaluator
  import bse_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_scan_tick,
  input wire logic [BSE_NUM_BEAMS-1:0] i_beam_status,
  input wire logic i_sw_serial_model,
  input wire logic [1:0] i_sw_analog_sel,
  input wire logic i_sw_invert,
  input wire logic i_sw_near,
  input wire logic [2:0] i_sw_serial_sel,
  output logic [BSE_NUM_BEAMS-1:0] o_bitmap,
  output logic [BSE_IDX_W-1:0] o_first_blocked_index,
  output logic [BSE_IDX_W-1:0] o_first_open_index,
  output logic [BSE_IDX_W-1:0] o_last_blocked_index,
  output logic [BSE_IDX_W-1:0] o_last_open_index,
  output logic [BSE_IDX_W-1:0] o_blocked_count,
  output logic [BSE_IDX_W-1:0] o_blocked_span,
  output logic o_result_valid,
  output logic o_serial_bitmap_mode,
  output logic [BSE_IDX_W-1:0] o_serial_value_a,
  output logic [BSE_IDX_W-1:0] o_serial_value_b,
  output logic [BSE_DAC_W-1:0] o_analog_code,
  output logic o_analog_valid,
  output logic o_near_mode,
  output logic o_config_ready
);
  localparam int SW_W = 8;
  localparam int PIN_W = BSE_NUM_BEAMS + SW_W;

  logic [PIN_W-1:0] pin_sync1;
  logic [PIN_W-1:0] pin_sync2;
  logic [BSE_NUM_BEAMS-1:0] beam_sync;
  logic [SW_W-1:0] sw_sync;
  bse_cfg_state_type cfg_state;
  logic [1:0] settle_count;
  logic cfg_serial_model;
  logic [1:0] cfg_analog_sel;
  logic cfg_invert;
  logic [2:0] cfg_serial_sel;
  logic [BSE_NUM_BEAMS-1:0] snapshot;
  logic snap_valid;
  logic [BSE_IDX_W-1:0] next_first_blocked;
  logic [BSE_IDX_W-1:0] next_first_open;
  logic [BSE_IDX_W-1:0] next_last_blocked;
  logic [BSE_IDX_W-1:0] next_last_open;
  logic [BSE_IDX_W-1:0] next_count;
  logic [BSE_IDX_W-1:0] next_span;
  logic [BSE_IDX_W-1:0] next_serial_a;
  logic [BSE_IDX_W-1:0] next_serial_b;
  logic [BSE_IDX_W-1:0] analog_value;
  logic analog_enable;

  // Beam and switch levels come from pins; only the second stage is read.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pin_sync1 <= '0;
      pin_sync2 <= '0;
    end else begin
      pin_sync1 <= {i_sw_serial_sel, i_sw_near, i_sw_invert,
                    i_sw_analog_sel, i_sw_serial_model, i_beam_status};
      pin_sync2 <= pin_sync1;
    end
  end
  assign beam_sync = pin_sync2[BSE_NUM_BEAMS-1:0];
  assign sw_sync = pin_sync2[PIN_W-1:BSE_NUM_BEAMS];

  // Switches are caught once after the synchronisers have filled.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cfg_state <= BSE_CFG_SETTLE;
      settle_count <= 2'h0;
    end else begin
      case (cfg_state)
        BSE_CFG_SETTLE: begin
          settle_count <= settle_count + 2'h1;
          if (settle_count == BSE_SETTLE_CYCLES) begin
            cfg_state <= BSE_CFG_LATCH;
          end
        end
        BSE_CFG_LATCH: cfg_state <= BSE_CFG_RUN;
        default: cfg_state <= BSE_CFG_RUN; // R15
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cfg_serial_model <= 1'b0;
      cfg_analog_sel <= BSE_AN_SPAN;
      cfg_invert <= 1'b0;
      o_near_mode <= 1'b0;
      cfg_serial_sel <= BSE_SER_BITMAP;
    end else if (cfg_state == BSE_CFG_LATCH) begin
      cfg_serial_model <= sw_sync[0]; // R15
      cfg_analog_sel <= sw_sync[2:1];
      cfg_invert <= sw_sync[3];
      o_near_mode <= sw_sync[4]; // R12
      cfg_serial_sel <= sw_sync[7:5];
    end
  end
  assign o_config_ready = (cfg_state == BSE_CFG_RUN);

  // Snapshot keeps the derived values consistent with a single scan.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      snapshot <= '0;
      snap_valid <= 1'b0;
    end else begin
      snap_valid <= i_scan_tick && o_config_ready;
      if (i_scan_tick && o_config_ready) begin
        snapshot <= beam_sync; // R3
      end
    end
  end

  always_comb begin
    next_first_blocked = BSE_IDX_NONE;
    next_first_open = BSE_IDX_NONE;
    next_last_blocked = BSE_IDX_NONE;
    next_last_open = BSE_IDX_NONE;
    next_count = BSE_IDX_NONE;
    for (int i = 0; i < BSE_NUM_BEAMS; i++) begin
      if (snapshot[i]) begin
        next_last_blocked = BSE_IDX_W'(i + 1); // R8 R1
        next_count = next_count + BSE_IDX_ONE; // R6
      end else begin
        next_last_open = BSE_IDX_W'(i + 1); // R9
      end
    end
    for (int i = BSE_NUM_BEAMS - 1; i >= 0; i--) begin
      if (snapshot[i]) begin
        next_first_blocked = BSE_IDX_W'(i + 1); // R4
      end else begin
        next_first_open = BSE_IDX_W'(i + 1); // R5
      end
    end
    if (next_first_blocked == BSE_IDX_NONE) begin
      next_span = BSE_IDX_NONE; // R16
    end else begin
      next_span = next_last_blocked - next_first_blocked + BSE_IDX_ONE; // R7
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_bitmap <= '0;
      o_first_blocked_index <= BSE_IDX_NONE;
      o_first_open_index <= BSE_IDX_NONE;
      o_last_blocked_index <= BSE_IDX_NONE;
      o_last_open_index <= BSE_IDX_NONE;
      o_blocked_count <= BSE_IDX_NONE;
      o_blocked_span <= BSE_IDX_NONE;
      o_serial_value_a <= BSE_IDX_NONE;
      o_serial_value_b <= BSE_IDX_NONE;
      o_result_valid <= 1'b0;
    end else begin
      o_result_valid <= snap_valid; // R3
      if (snap_valid) begin
        o_bitmap <= snapshot; // R2 R10
        o_first_blocked_index <= next_first_blocked;
        o_first_open_index <= next_first_open;
        o_last_blocked_index <= next_last_blocked;
        o_last_open_index <= next_last_open;
        o_blocked_count <= next_count;
        o_blocked_span <= next_span;
        o_serial_value_a <= next_serial_a; // R11
        o_serial_value_b <= next_serial_b; // R11
      end
    end
  end

  // The pair is picked from the new values and registered with them, so
  // the host never sees one half of a pair ahead of the other.
  always_comb begin
    o_serial_bitmap_mode = 1'b0;
    next_serial_a = BSE_IDX_NONE;
    next_serial_b = BSE_IDX_NONE;
    if (cfg_serial_model) begin
      case (cfg_serial_sel)
        BSE_SER_FB_CNT: begin
          next_serial_a = next_first_blocked; // R11
          next_serial_b = next_count;
        end
        BSE_SER_FO_SPAN: begin
          next_serial_a = next_first_open;
          next_serial_b = next_span;
        end
        BSE_SER_LB_CNT: begin
          next_serial_a = next_last_blocked;
          next_serial_b = next_count;
        end
        BSE_SER_LO_SPAN: begin
          next_serial_a = next_last_open;
          next_serial_b = next_span;
        end
        BSE_SER_FB_LB: begin
          next_serial_a = next_first_blocked;
          next_serial_b = next_last_blocked;
        end
        default: begin
          o_serial_bitmap_mode = 1'b1; // R10 R11
        end
      endcase
    end
  end

  always_comb begin
    analog_enable = 1'b1;
    analog_value = o_blocked_span;
    if (!cfg_serial_model) begin
      case (cfg_analog_sel)
        BSE_AN_LAST_BLK: analog_value = o_last_blocked_index;
        BSE_AN_COUNT: analog_value = o_blocked_count;
        BSE_AN_FIRST_BLK: analog_value = o_first_blocked_index;
        default: analog_value = o_blocked_span;
      endcase
    end else begin
      case (cfg_serial_sel)
        BSE_SER_FO_SPAN: analog_value = o_last_blocked_index;
        BSE_SER_LB_CNT: analog_value = o_blocked_count;
        BSE_SER_LO_SPAN: analog_value = o_first_blocked_index;
        BSE_SER_FB_LB: analog_value = o_blocked_count;
        BSE_SER_CONT_MAP: analog_enable = 1'b0;
        BSE_SER_HOLES: analog_enable = 1'b0;
        default: analog_value = o_blocked_span;
      endcase
    end
  end

  // The scaler loads on every result, one scan at a time.
  bse_analog_scaler u_scaler (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_load(o_result_valid), // R14
    .i_enable(analog_enable),
    .i_invert(cfg_invert),
    .i_value(analog_value),
    .o_code(o_analog_code),
    .o_valid(o_analog_valid)
  );

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_tick_to_result: assert property ( // R3
    i_scan_tick && o_config_ready |-> ##2 o_result_valid)
    else $error("Result did not follow scan tick by two cycles.");
  a_bitmap_sampled: assert property ( // R2
    i_scan_tick && o_config_ready |-> ##2 o_bitmap == $past(beam_sync, 2))
    else $error("Bitmap does not match sampled beams.");
  a_first_blk_low: assert property ( // R4
    o_result_valid && o_first_blocked_index != BSE_IDX_NONE |->
      o_bitmap[o_first_blocked_index - 1] &&
      ((o_bitmap & ((16'h0001 << (o_first_blocked_index - 1)) - 16'h0001))
        == 16'h0000))
    else $error("First blocked index wrong.");
  a_first_open_ok: assert property ( // R5
    o_result_valid && o_first_open_index != BSE_IDX_NONE |->
      !o_bitmap[o_first_open_index - 1])
    else $error("First open index points at blocked beam.");
  a_count_ones: assert property ( // R6
    o_result_valid |-> o_blocked_count == BSE_IDX_W'($countones(o_bitmap)))
    else $error("Blocked count wrong.");
  a_span_formula: assert property ( // R7
    o_result_valid && o_first_blocked_index != BSE_IDX_NONE |->
      o_blocked_span ==
        o_last_blocked_index - o_first_blocked_index + BSE_IDX_ONE)
    else $error("Blocked span wrong.");
  a_last_blk_high: assert property ( // R8
    o_result_valid && o_last_blocked_index != BSE_IDX_NONE |->
      o_bitmap[o_last_blocked_index - 1] &&
      ((o_bitmap >> o_last_blocked_index) == 16'h0000))
    else $error("Last blocked index wrong.");
  a_last_open_ok: assert property ( // R9
    o_result_valid && o_last_open_index != BSE_IDX_NONE |->
      !o_bitmap[o_last_open_index - 1])
    else $error("Last open index points at blocked beam.");
  a_empty_zero: assert property ( // R16
    o_result_valid && o_bitmap == 16'h0000 |->
      o_blocked_count == BSE_IDX_NONE && o_blocked_span == BSE_IDX_NONE &&
      o_first_blocked_index == BSE_IDX_NONE &&
      o_last_blocked_index == BSE_IDX_NONE)
    else $error("Blocked values not zero with clear curtain.");
  a_analog_refresh: assert property ( // R14
    o_result_valid |-> ##1 o_analog_valid)
    else $error("Analogue output not refreshed after scan.");
  a_config_frozen: assert property ( // R15
    o_config_ready |-> ##1 o_config_ready && $stable({o_near_mode,
      cfg_serial_model, cfg_analog_sel, cfg_invert, cfg_serial_sel}))
    else $error("Configuration changed after latch.");

  c_full_block: cover property (o_result_valid && o_bitmap == 16'hffff);
  c_clear: cover property (o_result_valid && o_bitmap == 16'h0000);
  c_hole: cover property (o_result_valid && o_blocked_span > o_blocked_count);
  c_pair_mode: cover property (o_result_valid && !o_serial_bitmap_mode &&
    cfg_serial_model);
endmodule

// File: testbench/bse_plc_reader.sv
// Purpose: Behavioural host that reads the serial measurement pair.
// Assumes: Results are read on the cycle that flags them as new.
// Notes: The host never stalls the device, so it reads on every pulse.
`timescale 1ns/10ps
module bse_plc_reader
  import bse_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_result_valid,
  input wire logic i_bitmap_mode,
  input wire logic [BSE_IDX_W-1:0] i_value_a,
  input wire logic [BSE_IDX_W-1:0] i_value_b,
  output logic [BSE_IDX_W-1:0] o_value_a,
  output logic [BSE_IDX_W-1:0] o_value_b,
  output logic o_bitmap_mode
);
  initial begin
    o_value_a = 5'h1f;
    o_value_b = 5'h1f;
    o_bitmap_mode = 1'h1;
  end

  // The pair is taken only when flagged; stale values would hide a late
  // update.
  always @(posedge i_clock) begin
    if (i_result_valid === 1'b1) begin
      o_value_a <= i_value_a;
      o_value_b <= i_value_b;
      o_bitmap_mode <= i_bitmap_mode;
    end
  end
endmodule

// File: testbench/tb_beam_status_evaluator.sv
// Purpose: Self-checking bench for the beam status evaluator.
// Assumes: Sixteen beams, twelve-bit analogue code.
// Notes: Each power-up latches one switch setting, so fourteen are used.
`timescale 1ns/10ps
module tb_beam_status_evaluator
  import bse_pkg::*;
;
  typedef struct packed {
    logic [15:0] beams;
    logic [4:0] fb, fo, lb, lo, cnt, span;
  } bse_row_type;
  logic i_clock = 0, i_rst_n = 0, i_scan_tick = 0;
  logic [15:0] i_beam_status = 16'h0000;
  logic i_sw_serial_model = 0, i_sw_invert = 0, i_sw_near = 0;
  logic [1:0] i_sw_analog_sel = 2'h0;
  logic [2:0] i_sw_serial_sel = 3'h0;
  logic [15:0] o_bitmap;
  logic [4:0] o_fb, o_fo, o_lb, o_lo, o_cnt, o_span, o_a, o_b, plc_a, plc_b;
  logic o_result_valid, o_bmode, o_analog_valid, o_near_mode, o_ready;
  logic plc_bmode;
  logic [11:0] o_analog_code;
  int fails = 0, n_checks = 0, cycles = 0;
  bse_row_type rows [6] = '{
    '{16'h0000, 5'h00, 5'h01, 5'h00, 5'h10, 5'h00, 5'h00},
    '{16'hffff, 5'h01, 5'h00, 5'h10, 5'h00, 5'h10, 5'h10},
    '{16'h0078, 5'h04, 5'h01, 5'h07, 5'h10, 5'h04, 5'h04},
    '{16'h0092, 5'h02, 5'h01, 5'h08, 5'h10, 5'h03, 5'h07},
    '{16'h8001, 5'h01, 5'h02, 5'h10, 5'h0f, 5'h02, 5'h10},
    '{16'h7fff, 5'h01, 5'h10, 5'h0f, 5'h10, 5'h0f, 5'h0f}};
  // Beams 2, 5 and 8 blocked, for each serial function code: value pair,
  // bitmap flag and analogue code; codes 5 and 7 switch the analogue off.
  logic [22:0] modes [8] = '{
    {5'h00, 5'h00, 1'h1, 12'h6ff}, {5'h02, 5'h03, 1'h0, 12'h6ff},
    {5'h01, 5'h07, 1'h0, 12'h7ff}, {5'h08, 5'h03, 1'h0, 12'h2ff},
    {5'h10, 5'h07, 1'h0, 12'h1ff}, {5'h00, 5'h00, 1'h1, 12'h000},
    {5'h02, 5'h08, 1'h0, 12'h2ff}, {5'h00, 5'h00, 1'h1, 12'h000}};
  // Same pattern on the analogue-only model: span, last, count, first.
  logic [11:0] an_codes [4] = '{12'h6ff, 12'h7ff, 12'h2ff, 12'h1ff};

  bse_beam_status_evaluator DUT (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_scan_tick(i_scan_tick), .i_beam_status(i_beam_status),
    .i_sw_serial_model(i_sw_serial_model),
    .i_sw_analog_sel(i_sw_analog_sel), .i_sw_invert(i_sw_invert),
    .i_sw_near(i_sw_near), .i_sw_serial_sel(i_sw_serial_sel),
    .o_bitmap(o_bitmap), .o_first_blocked_index(o_fb),
    .o_first_open_index(o_fo), .o_last_blocked_index(o_lb),
    .o_last_open_index(o_lo), .o_blocked_count(o_cnt),
    .o_blocked_span(o_span), .o_result_valid(o_result_valid),
    .o_serial_bitmap_mode(o_bmode), .o_serial_value_a(o_a),
    .o_serial_value_b(o_b), .o_analog_code(o_analog_code),
    .o_analog_valid(o_analog_valid), .o_near_mode(o_near_mode),
    .o_config_ready(o_ready));

  bse_plc_reader u_plc (.i_clock(i_clock), .i_result_valid(o_result_valid),
    .i_bitmap_mode(o_bmode), .i_value_a(o_a), .i_value_b(o_b),
    .o_value_a(plc_a), .o_value_b(plc_b), .o_bitmap_mode(plc_bmode));

  initial begin
    forever #10 i_clock = ~i_clock;
  end

  task automatic report(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_idx(input logic [4:0] got, input logic [4:0] exp);
    report({11'h000, got}, {11'h000, exp});
  endtask
  task automatic chk_map(input logic [15:0] got, input logic [15:0] exp);
    report(got, exp);
  endtask
  task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
    report({4'h0, got}, {4'h0, exp});
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    report({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A tick sent before the switches settle must give no result.
  task automatic power_up(input logic ser, input logic [1:0] asel,
                          input logic inv, input logic near,
                          input logic [2:0] ssel);
    int n;
    {i_sw_serial_model, i_sw_analog_sel} = {ser, asel};
    {i_sw_invert, i_sw_near, i_sw_serial_sel} = {inv, near, ssel};
    i_rst_n = 0;
    repeat (4) @(negedge i_clock);
    chk_bit(o_ready, 1'b0);
    chk_bit(o_result_valid, 1'b0);
    i_rst_n = 1;
    @(negedge i_clock);
    i_scan_tick = 1;
    @(negedge i_clock);
    i_scan_tick = 0;
    repeat (3) begin
      @(negedge i_clock);
      chk_bit(o_result_valid, 1'b0);
    end
    n = 0;
    while (o_ready !== 1'b1 && n < 10) begin
      @(negedge i_clock);
      n++;
    end
    chk_bit(o_ready, 1'b1);
  endtask

  // Beam levels pass a two-stage synchroniser, so they lead the tick.
  task automatic scan(input logic [15:0] b, input logic [11:0] code);
    i_beam_status = b;
    repeat (3) @(negedge i_clock);
    i_scan_tick = 1;
    @(negedge i_clock);
    i_scan_tick = 0;
    chk_bit(o_result_valid, 1'b0);
    @(negedge i_clock);
    chk_bit(o_result_valid, 1'b1);
    @(negedge i_clock);
    chk_bit(o_analog_valid, 1'b1);
    chk_code(o_analog_code, code);
  endtask

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    logic [16:0] prod;
    power_up(1'b1, 2'h0, 1'b0, 1'b0, BSE_SER_FB_CNT);
    chk_bit(o_near_mode, 1'b0);
    foreach (rows[i]) begin
      prod = ({12'h000, rows[i].span} * 17'h00fff) >> 4;
      scan(rows[i].beams, prod[11:0]);
      chk_map(o_bitmap, rows[i].beams);
      chk_idx(o_fb, rows[i].fb);
      chk_idx(o_fo, rows[i].fo);
      chk_idx(o_lb, rows[i].lb);
      chk_idx(o_lo, rows[i].lo);
      chk_idx(o_cnt, rows[i].cnt);
      chk_idx(o_span, rows[i].span);
      chk_idx(plc_a, rows[i].fb);
      chk_idx(plc_b, rows[i].cnt);
      chk_bit(plc_bmode, 1'b0);
    end
    for (int m = 0; m < 8; m++) begin
      power_up(1'b1, BSE_AN_SPAN, 1'b0, 1'b0, 3'(m));
      scan(16'h0092, modes[m][11:0]);
      chk_idx(plc_a, modes[m][22:18]);
      chk_idx(plc_b, modes[m][17:13]);
      chk_bit(plc_bmode, modes[m][12]);
    end
    for (int m = 0; m < 4; m++) begin
      power_up(1'b0, 2'(m), 1'b0, 1'b0, BSE_SER_BITMAP);
      scan(16'h0092, an_codes[m]);
      chk_idx(o_a, 5'h00);
      chk_bit(o_bmode, 1'b0);
    end
    // Analogue-only, inverted, near; later switch moves must not count.
    power_up(1'b0, BSE_AN_FIRST_BLK, 1'b1, 1'b1, BSE_SER_BITMAP);
    i_sw_analog_sel = BSE_AN_COUNT;
    i_sw_near = 0;
    i_sw_invert = 0;
    scan(16'h0092, 12'he00);
    chk_bit(o_near_mode, 1'b1);
    chk_bit(o_bmode, 1'b0);
    chk_map(o_bitmap, 16'h0092);
    summarize();
  end
endmodule
